// file: src/osl_consts.svh
/*
 * constants of the origin search and limit control block: register map,
 * field positions, reset values and timing figures.
 * assumes inclusion by bare name from each design file.
 */
`ifndef OSL_CONSTS_SVH
`define OSL_CONSTS_SVH

// ==========================================================
// register byte addresses
`define OSL_ADDR_CFG 8'h00
`define OSL_ADDR_INIT 8'h04
`define OSL_ADDR_HIGH 8'h08
`define OSL_ADDR_PROX 8'h0c
`define OSL_ADDR_RATE 8'h10
`define OSL_ADDR_CTRL 8'h14
`define OSL_ADDR_STAT 8'h18
`define OSL_ADDR_SPEED 8'h1c

// ==========================================================
// configuration fields
`define OSL_CFG_W 11
`define OSL_CFG_RST 11'h000
`define OSL_CFG_LIM_ALWAYS 0
`define OSL_CFG_LIM_NO 1
`define OSL_CFG_CLR_ORG 2
`define OSL_CFG_SCURVE 3
`define OSL_CFG_SRCH_EN 4
`define OSL_CFG_DIR_CCW 5
`define OSL_CFG_PAT_LO 6
`define OSL_CFG_PAT_HI 7
`define OSL_CFG_LIM_ERR 8
`define OSL_CFG_ORG_NO 9
`define OSL_CFG_PROX_NO 10
`define OSL_PAT_ON_OFF 2'h0
`define OSL_PAT_ON 2'h1
`define OSL_PAT_NONE 2'h2

// ==========================================================
// control and status bits
`define OSL_CTRL_START 0
`define OSL_CTRL_STOP 1
`define OSL_CTRL_JOG_CW 2
`define OSL_CTRL_JOG_CCW 3
`define OSL_STAT_BUSY 0
`define OSL_STAT_ORG_DEF 1
`define OSL_STAT_ERR 2
`define OSL_STAT_REFUSED 3
`define OSL_STAT_FOUND 4
`define OSL_STAT_DIR 5
`define OSL_STAT_CW_LIM 6
`define OSL_STAT_CCW_LIM 7

// ==========================================================
// widths and timing
`define OSL_SPD_W 17
`define OSL_SPD_RST 17'h00000
`define OSL_RATE_W 16
`define OSL_RATE_RST 16'h0000
`define OSL_PHASE_W 25
`define OSL_CLK_HZ 20000000
`define OSL_RAMP_MS 4
`define OSL_RAMP_CYC (`OSL_CLK_HZ / 1000 * `OSL_RAMP_MS)
`define OSL_TICK_W 17
`define OSL_IN_W 4
`define OSL_IN_CW 0
`define OSL_IN_CCW 1
`define OSL_IN_PROX 2
`define OSL_IN_ORG 3

`endif

// file: src/osl_pkg.sv
/*
 * types of the origin search and limit control block.
 * assumes osl_consts.svh for widths.
 */
`include "osl_consts.svh"

package osl_pkg;
    typedef enum logic [2:0] {
        OSL_IDLE,
        OSL_JOG,
        OSL_HIGH,
        OSL_PROX_ON,
        OSL_PROX
    } osl_state_type;

    typedef struct packed {
        logic [`OSL_IN_W-1:0] s1;
        logic [`OSL_IN_W-1:0] s2;
        logic [`OSL_IN_W-1:0] s3;
        logic [`OSL_IN_W-1:0] q;
    } osl_sync_type;

    typedef struct packed {
        logic [`OSL_SPD_W-1:0] speed;
        logic [`OSL_PHASE_W-1:0] phase;
        logic [`OSL_TICK_W-1:0] tick;
        logic pulse;
    } osl_gen_type;

    typedef struct packed {
        osl_state_type state;
        logic [`OSL_CFG_W-1:0] cfg;
        logic [`OSL_SPD_W-1:0] init_spd;
        logic [`OSL_SPD_W-1:0] high_spd;
        logic [`OSL_SPD_W-1:0] prox_spd;
        logic [`OSL_RATE_W-1:0] rate;
        logic dir;
        logic rev;
        logic org_def;
        logic err;
        logic refused;
        logic found;
        logic org_prev;
        logic prox_prev;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic pulse;
    } osl_top_type;
endpackage

// file: src/osl_in_sync.sv
/*
 * three-stage synchroniser for the sensor pins; an output changes only
 * when the second and third stages agree.
 * assumes raw pins asynchronous to pclk.
 */
`timescale 1ns/100ps
`include "osl_consts.svh"

module osl_in_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`OSL_IN_W-1:0] raw,
    output logic [`OSL_IN_W-1:0] clean
);
    import osl_pkg::*;

    osl_sync_type s_q;
    osl_sync_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.s1 = raw;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        // disagreement between stages keeps the old value (glitch filter)
        s_d.q = (~(s_q.s2 ^ s_q.s3) & s_q.s2) | ((s_q.s2 ^ s_q.s3) & s_q.q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign clean = s_q.q;
endmodule

// file: src/osl_pulse_gen.sv
/*
 * pulse rate generator with linear or s-shaped ramp toward a target.
 * assumes run held high for the whole move; speeds in pulses per second.
 */
`timescale 1ns/100ps
`include "osl_consts.svh"

module osl_pulse_gen #(
    parameter int unsigned RAMP_CYC = `OSL_RAMP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic s_curve,
    input wire logic [`OSL_SPD_W-1:0] init_spd,
    input wire logic [`OSL_SPD_W-1:0] target_spd,
    input wire logic [`OSL_RATE_W-1:0] rate,
    output logic pulse,
    output logic [`OSL_SPD_W-1:0] speed
);
    import osl_pkg::*;

    osl_gen_type g_q;
    osl_gen_type g_d;

    // step of one ramp tick; s-curve halves it near the target
    function automatic logic [`OSL_SPD_W-1:0] step_of(
        input logic [`OSL_SPD_W-1:0] diff,
        input logic [`OSL_RATE_W-1:0] r,
        input logic sc
    );
        logic [`OSL_SPD_W+1:0] r4;
        logic [`OSL_SPD_W-1:0] st;
        r4 = {{`OSL_SPD_W-`OSL_RATE_W{1'b0}}, r, 2'b00};
        st = {{`OSL_SPD_W-`OSL_RATE_W{1'b0}}, r};
        if (sc && ({2'b00, diff} < r4)) begin
            st = st >> 1;
        end
        if (r == '0 || st > diff || st == '0) begin
            st = diff;
        end
        return st;
    endfunction

    logic [`OSL_PHASE_W:0] sum;

    always_comb begin
        g_d = g_q;
        sum = {1'b0, g_q.phase} + {{`OSL_PHASE_W-`OSL_SPD_W+1{1'b0}}, g_q.speed};
        g_d.pulse = 1'b0;
        if (!run) begin
            g_d.speed = init_spd;
            g_d.phase = '0;
            g_d.tick = '0;
        end else begin
            if (sum >= (`OSL_PHASE_W+1)'(`OSL_CLK_HZ)) begin
                g_d.phase = `OSL_PHASE_W'(sum - (`OSL_PHASE_W+1)'(`OSL_CLK_HZ));
                g_d.pulse = 1'b1;
            end else begin
                g_d.phase = sum[`OSL_PHASE_W-1:0];
            end
            if (g_q.tick == `OSL_TICK_W'(RAMP_CYC - 1)) begin
                g_d.tick = '0;
                // trapezoid or s-shape chosen by step_of
                if (g_q.speed < target_spd) begin
                    g_d.speed = g_q.speed + step_of(target_spd - g_q.speed, rate, s_curve);
                end else if (g_q.speed > target_spd) begin
                    g_d.speed = g_q.speed - step_of(g_q.speed - target_spd, rate, s_curve);
                end
            end else begin
                g_d.tick = g_q.tick + `OSL_TICK_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            g_q <= '0;
        end else begin
            g_q <= g_d;
        end
    end

    assign pulse = g_q.pulse;
    assign speed = g_q.speed;
endmodule

// file: src/osl_top.sv
/*
 * origin search and limit control for one pulse output channel, with an
 * apb register slave, limit handling and the search sequencer.
 * assumes an apb master on pclk and sensor pins asynchronous to it.
 */
// Local design decisions: the register addresses and the APB register port.
// Functional notes
// - search-only limits act during search only
// - limit polarity follows normally-closed or normally-open
// - hold option: stop, keep origin status
// - clear option: stop, origin becomes undefined
// - moves start at configured initial speed
// - refuse search unless high > prox > init
// - linear or s-shaped ramping per setting
// - search runs only when enabled
// - origin is rising edge in search direction
// - search moves cw or ccw as configured
// - proximity pattern gates origin acceptance
// - limit in search direction: reverse or error
// - after proximity run at proximity speed
// - stop pulses when origin detected
`timescale 1ns/100ps
`include "osl_consts.svh"

module osl_top #(
    parameter int unsigned RAMP_CYC = `OSL_RAMP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cw_limit_in,
    input wire logic ccw_limit_in,
    input wire logic prox_in,
    input wire logic origin_in,
    output logic pulse_out,
    output logic dir_ccw_out
);
    import osl_pkg::*;

    osl_top_type s_q;
    osl_top_type s_d;
    logic [`OSL_IN_W-1:0] syn;
    logic gen_pulse;
    logic [`OSL_SPD_W-1:0] gen_speed;
    logic [`OSL_SPD_W-1:0] target;
    logic run;
    logic cw_act;
    logic ccw_act;
    logic prox_act;
    logic org_act;
    logic lim_fwd;
    logic prox_rise;
    logic prox_fall;
    logic org_rise;
    logic wr;
    logic start_cmd;
    logic stop_cmd;
    logic jog_cmd;
    logic bad_spd;
    logic limit_stop;
    logic [1:0] pat;

    // ==========================================================
    // pins and pulse generation
    osl_in_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .raw({origin_in, prox_in, ccw_limit_in, cw_limit_in}),
        .clean(syn)
    );

    assign run = (s_q.state != OSL_IDLE);
    assign target = (s_q.state == OSL_JOG) ? s_q.init_spd :
                    (s_q.state == OSL_HIGH) ? s_q.high_spd : s_q.prox_spd;

    osl_pulse_gen #(.RAMP_CYC(RAMP_CYC)) u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .s_curve(s_q.cfg[`OSL_CFG_SCURVE]),
        .init_spd(s_q.init_spd),
        .target_spd(target),
        .rate(s_q.rate),
        .pulse(gen_pulse),
        .speed(gen_speed)
    );

    // ==========================================================
    // sensor decode
    always_comb begin
        // normally closed: the contact opening is the active state
        cw_act = s_q.cfg[`OSL_CFG_LIM_NO] ? syn[`OSL_IN_CW] : ~syn[`OSL_IN_CW];
        ccw_act = s_q.cfg[`OSL_CFG_LIM_NO] ? syn[`OSL_IN_CCW] : ~syn[`OSL_IN_CCW];
        prox_act = s_q.cfg[`OSL_CFG_PROX_NO] ? syn[`OSL_IN_PROX] : ~syn[`OSL_IN_PROX];
        org_act = s_q.cfg[`OSL_CFG_ORG_NO] ? syn[`OSL_IN_ORG] : ~syn[`OSL_IN_ORG];
        lim_fwd = s_q.dir ? ccw_act : cw_act;
        prox_rise = prox_act & ~s_q.prox_prev;
        prox_fall = ~prox_act & s_q.prox_prev;
        org_rise = org_act & ~s_q.org_prev;
        pat = s_q.cfg[`OSL_CFG_PAT_HI:`OSL_CFG_PAT_LO];
        bad_spd = (s_q.high_spd <= s_q.prox_spd) || (s_q.prox_spd <= s_q.init_spd);
        wr = psel & penable & s_q.pready & pwrite;
        start_cmd = wr && paddr == `OSL_ADDR_CTRL && pwdata[`OSL_CTRL_START];
        stop_cmd = wr && paddr == `OSL_ADDR_CTRL && pwdata[`OSL_CTRL_STOP];
        jog_cmd = wr && paddr == `OSL_ADDR_CTRL &&
                  (pwdata[`OSL_CTRL_JOG_CW] | pwdata[`OSL_CTRL_JOG_CCW]);
    end

    // ==========================================================
    // registers, bus and sequencer
    always_comb begin
        s_d = s_q;
        limit_stop = 1'b0;
        s_d.org_prev = org_act;
        s_d.prox_prev = prox_act;
        // one wait-free access: answer registered from the setup cycle
        s_d.pready = psel & ~penable;
        s_d.pslverr = 1'b0;
        s_d.prdata = '0;
        if (psel & ~penable) begin
            if (paddr == `OSL_ADDR_CFG) begin
                s_d.prdata = {{32-`OSL_CFG_W{1'b0}}, s_q.cfg};
            end else if (paddr == `OSL_ADDR_INIT) begin
                s_d.prdata = {{32-`OSL_SPD_W{1'b0}}, s_q.init_spd};
            end else if (paddr == `OSL_ADDR_HIGH) begin
                s_d.prdata = {{32-`OSL_SPD_W{1'b0}}, s_q.high_spd};
            end else if (paddr == `OSL_ADDR_PROX) begin
                s_d.prdata = {{32-`OSL_SPD_W{1'b0}}, s_q.prox_spd};
            end else if (paddr == `OSL_ADDR_RATE) begin
                s_d.prdata = {{32-`OSL_RATE_W{1'b0}}, s_q.rate};
            end else if (paddr == `OSL_ADDR_CTRL) begin
                s_d.prdata = '0;
            end else if (paddr == `OSL_ADDR_STAT) begin
                s_d.prdata[`OSL_STAT_BUSY] = run;
                s_d.prdata[`OSL_STAT_ORG_DEF] = s_q.org_def;
                s_d.prdata[`OSL_STAT_ERR] = s_q.err;
                s_d.prdata[`OSL_STAT_REFUSED] = s_q.refused;
                s_d.prdata[`OSL_STAT_FOUND] = s_q.found;
                s_d.prdata[`OSL_STAT_DIR] = s_q.dir;
                s_d.prdata[`OSL_STAT_CW_LIM] = cw_act;
                s_d.prdata[`OSL_STAT_CCW_LIM] = ccw_act;
            end else if (paddr == `OSL_ADDR_SPEED) begin
                s_d.prdata = {{32-`OSL_SPD_W{1'b0}}, gen_speed};
            end else begin
                s_d.pslverr = 1'b1;
            end
        end
        if (wr) begin
            if (paddr == `OSL_ADDR_CFG) begin
                s_d.cfg = pwdata[`OSL_CFG_W-1:0];
            end else if (paddr == `OSL_ADDR_INIT) begin
                s_d.init_spd = pwdata[`OSL_SPD_W-1:0];
            end else if (paddr == `OSL_ADDR_HIGH) begin
                s_d.high_spd = pwdata[`OSL_SPD_W-1:0];
            end else if (paddr == `OSL_ADDR_PROX) begin
                s_d.prox_spd = pwdata[`OSL_SPD_W-1:0];
            end else if (paddr == `OSL_ADDR_RATE) begin
                s_d.rate = pwdata[`OSL_RATE_W-1:0];
            end else if (paddr == `OSL_ADDR_STAT) begin
                // write one to clear; later sets in this process win
                s_d.err = s_q.err & ~pwdata[`OSL_STAT_ERR];
                s_d.refused = s_q.refused & ~pwdata[`OSL_STAT_REFUSED];
                s_d.found = s_q.found & ~pwdata[`OSL_STAT_FOUND];
            end
        end
        case (s_q.state)
            OSL_IDLE: begin
                if (start_cmd) begin
                    if (!s_q.cfg[`OSL_CFG_SRCH_EN] || bad_spd) begin
                        s_d.refused = 1'b1;
                    end else begin
                        s_d.dir = s_q.cfg[`OSL_CFG_DIR_CCW];
                        s_d.rev = 1'b0;
                        // no proximity sensor: run at proximity speed from start
                        s_d.state = (pat == `OSL_PAT_NONE) ? OSL_PROX : OSL_HIGH;
                    end
                end else if (jog_cmd) begin
                    s_d.dir = pwdata[`OSL_CTRL_JOG_CCW];
                    s_d.state = OSL_JOG;
                end
            end
            OSL_JOG: begin
                if (stop_cmd) begin
                    s_d.state = OSL_IDLE;
                end else if (lim_fwd && s_q.cfg[`OSL_CFG_LIM_ALWAYS]) begin
                    s_d.state = OSL_IDLE;
                    limit_stop = 1'b1;
                end
            end
            default: begin
                if (stop_cmd) begin
                    s_d.state = OSL_IDLE;
                end else if (lim_fwd) begin
                    // a second limit while reversed means no origin was passed
                    if (!s_q.rev && !s_q.cfg[`OSL_CFG_LIM_ERR]) begin
                        s_d.dir = ~s_q.dir;
                        s_d.rev = 1'b1;
                    end else begin
                        s_d.state = OSL_IDLE;
                        s_d.err = 1'b1;
                        limit_stop = 1'b1;
                    end
                end else if (s_q.rev) begin
                    // back past the sensor area: resume at proximity speed
                    if ((pat == `OSL_PAT_NONE) ? org_rise : prox_fall) begin
                        s_d.dir = s_q.cfg[`OSL_CFG_DIR_CCW];
                        s_d.rev = 1'b0;
                        s_d.state = OSL_PROX;
                    end
                end else if (s_q.state == OSL_HIGH) begin
                    if (prox_rise) begin
                        s_d.state = (pat == `OSL_PAT_ON_OFF) ? OSL_PROX_ON : OSL_PROX;
                    end
                end else if (s_q.state == OSL_PROX_ON) begin
                    if (prox_fall) begin
                        s_d.state = OSL_PROX;
                    end
                end else if (org_rise) begin
                    s_d.state = OSL_IDLE;
                    s_d.org_def = 1'b1;
                    s_d.found = 1'b1;
                end
            end
        endcase
        if (limit_stop && s_q.cfg[`OSL_CFG_CLR_ORG]) begin
            s_d.org_def = 1'b0;
        end
        // hold option leaves org_def untouched
        s_d.pulse = gen_pulse & run & (s_d.state != OSL_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.state <= OSL_IDLE;
            s_q.cfg <= `OSL_CFG_RST;
            s_q.init_spd <= `OSL_SPD_RST;
            s_q.high_spd <= `OSL_SPD_RST;
            s_q.prox_spd <= `OSL_SPD_RST;
            s_q.rate <= `OSL_RATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign pulse_out = s_q.pulse;
    assign dir_ccw_out = s_q.dir;

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    refuse_speeds_a: assert property (s_q.state == OSL_IDLE && start_cmd && bad_spd
        |=> s_q.state == OSL_IDLE && s_q.refused)
        else $error("search started with bad speed order");
    search_off_a: assert property (s_q.state == OSL_IDLE && start_cmd
        && !s_q.cfg[`OSL_CFG_SRCH_EN] |=> s_q.state == OSL_IDLE)
        else $error("search started while disabled");
    search_dir_a: assert property ($past(s_q.state) == OSL_IDLE
        && s_q.state inside {OSL_HIGH, OSL_PROX} |-> s_q.dir == s_q.cfg[`OSL_CFG_DIR_CCW])
        else $error("search left in wrong direction");
    jog_ignore_a: assert property (s_q.state == OSL_JOG && !s_q.cfg[`OSL_CFG_LIM_ALWAYS]
        && !stop_cmd |=> s_q.state == OSL_JOG)
        else $error("limit acted outside search");
    limit_hold_a: assert property (limit_stop && !s_q.cfg[`OSL_CFG_CLR_ORG]
        |=> s_q.state == OSL_IDLE && s_q.org_def == $past(s_q.org_def) && !pulse_out)
        else $error("hold option changed origin state");
    limit_clear_a: assert property (limit_stop && s_q.cfg[`OSL_CFG_CLR_ORG]
        |=> !s_q.org_def ##1 !pulse_out)
        else $error("clear option kept origin");
    reverse_dir_a: assert property (s_q.state inside {OSL_HIGH, OSL_PROX_ON, OSL_PROX}
        && lim_fwd && !stop_cmd && !s_q.rev && !s_q.cfg[`OSL_CFG_LIM_ERR]
        |=> s_q.dir != $past(s_q.dir) && s_q.rev)
        else $error("limit did not reverse the search");
    origin_stop_a: assert property (s_q.state == OSL_PROX && !s_q.rev && org_rise
        && !lim_fwd && !stop_cmd |=> s_q.state == OSL_IDLE && s_q.org_def ##1 !pulse_out)
        else $error("origin edge did not end search");
    prox_one_a: assert property (s_q.state == OSL_HIGH && pat == `OSL_PAT_ON && prox_rise
        && !lim_fwd && !stop_cmd && !s_q.rev |=> s_q.state == OSL_PROX)
        else $error("pattern 1 did not enter proximity run");
    start_speed_a: assert property ($rose(run) |=> gen_speed == $past(s_q.init_spd))
        else $error("move did not start at initial speed");
    prox_target_a: assert property (s_q.state inside {OSL_PROX_ON, OSL_PROX}
        && gen_speed > s_q.prox_spd |=> gen_speed <= $past(gen_speed))
        else $error("proximity run sped up above proximity speed");

    found_c: cover property (s_q.state == OSL_PROX ##1 s_q.found);
    reversed_c: cover property (s_q.rev ##1 !s_q.rev && s_q.state == OSL_PROX);
    refused_c: cover property ($rose(s_q.refused));
    limit_err_c: cover property ($rose(s_q.err));
    jog_stop_c: cover property (s_q.state == OSL_JOG ##1 s_q.state == OSL_IDLE);
endmodule

// file: test/osl_drive_model.sv
/*
 * motor drive and sensor model: tracks shaft position from step pulses and
 * drives the limit, proximity and origin pins from it.
 * assumes pulse_out and dir_ccw_out on pclk; no_pol[0] limit, [1] prox, [2] origin.
 */
`timescale 1ns/100ps
module osl_drive_model (
    input wire logic pclk,
    input wire logic park,
    input wire logic pulse_out,
    input wire logic dir_ccw_out,
    input wire logic [2:0] no_pol,
    output logic cw_limit_in,
    output logic ccw_limit_in,
    output logic prox_in,
    output logic origin_in,
    output int pos,
    output int gap
);
    int now;
    int last;
    // ==========================================================
    // shaft position; park only while the drive is idle
    always @(posedge pclk) begin
        now <= now + 1;
        if (park) begin
            pos <= 0;
        end else if (pulse_out === 1'b1) begin
            pos <= dir_ccw_out ? pos - 1 : pos + 1;
            gap <= now - last;
            last <= now;
        end
    end
    // ==========================================================
    // sensors; origin marks at 5, 12 and 18 tell the patterns apart
    assign cw_limit_in = (pos >= 40) ~^ no_pol[0];
    assign ccw_limit_in = (pos <= -8) ~^ no_pol[0];
    assign prox_in = (pos >= 10 && pos <= 15) ~^ no_pol[1];
    assign origin_in = (pos == 5 || pos == 12 || pos == 18) ~^ no_pol[2];
endmodule

// file: test/origin_search_limit_control_tb_top.sv
/*
 * self-checking bench for osl_top: apb master tasks and one task per scenario.
 * assumes the drive model stands on the motor side of the block.
 */
`timescale 1ns/100ps
`include "osl_consts.svh"
module origin_search_limit_control_tb_top;
    logic pclk = 0;
    logic presetn = 0;
    logic [7:0] paddr = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pulse_out;
    logic dir_ccw_out;
    logic cw_lim;
    logic ccw_lim;
    logic prox;
    logic org;
    logic park = 0;
    logic [2:0] no_pol = 0;
    int pos;
    int gap;
    int err_total = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic re;
    always #25 pclk = ~pclk;
    osl_top #(.RAMP_CYC(8)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cw_limit_in(cw_lim),
        .ccw_limit_in(ccw_lim), .prox_in(prox), .origin_in(org),
        .pulse_out(pulse_out), .dir_ccw_out(dir_ccw_out));
    osl_drive_model fs (.pclk(pclk), .park(park), .pulse_out(pulse_out),
        .dir_ccw_out(dir_ccw_out), .no_pol(no_pol), .cw_limit_in(cw_lim),
        .ccw_limit_in(ccw_lim), .prox_in(prox), .origin_in(org), .pos(pos), .gap(gap));
    // ==========================================================
    // reporting
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic give_up(input bit hit);
        if (hit) begin
            err_total++;
            report_and_stop();
        end
    endtask
    // ==========================================================
    // bus tasks
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        give_up(n >= 50);
        rd = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(`OSL_ADDR_STAT, 1'b0, 32'h0);
            n++;
        end while (rd[`OSL_STAT_BUSY] !== 1'b0 && n < 10000);
        give_up(n >= 10000);
    endtask
    // sensor polarity must match cfg before the pins are trusted
    task automatic setup(input logic [31:0] cfg, input logic [31:0] hi);
        no_pol <= {cfg[`OSL_CFG_ORG_NO], cfg[`OSL_CFG_PROX_NO], cfg[`OSL_CFG_LIM_NO]};
        park <= 1'b1;
        @(posedge pclk);
        park <= 1'b0;
        apb(`OSL_ADDR_CFG, 1'b1, cfg);
        apb(`OSL_ADDR_INIT, 1'b1, 32'd20000);
        apb(`OSL_ADDR_HIGH, 1'b1, hi);
        apb(`OSL_ADDR_PROX, 1'b1, 32'd50000);
        apb(`OSL_ADDR_RATE, 1'b1, 32'd1000);
        apb(`OSL_ADDR_STAT, 1'b1, 32'h1c);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        apb(`OSL_ADDR_CFG, 1'b0, 32'h0);
        check("cfg reset", 32'h0, rd);
        apb(`OSL_ADDR_STAT, 1'b0, 32'h0);
        check("stat reset", 32'h0, rd);
        apb(8'h40, 1'b0, 32'h0);
        check("unmapped", 32'h1, re);
    endtask
    task automatic t_refuse();
        for (int k = 0; k < 3; k++) begin
            setup(k == 0 ? 32'h0 : 32'h10, k == 1 ? 32'd50000 : 32'd100000);
            if (k == 2) begin
                apb(`OSL_ADDR_INIT, 1'b1, 32'd50000);
            end
            apb(`OSL_ADDR_CTRL, 1'b1, 32'h1);
            apb(`OSL_ADDR_STAT, 1'b0, 32'h0);
            check("refused", 32'h8, rd & 32'h1f);
        end
    endtask
    // marks at 5, 12, 18 separate patterns 2, 1, 0; odd run uses open contacts
    task automatic t_pattern();
        for (int p = 0; p < 3; p++) begin
            setup(32'h10 | (p << 6) | (p == 1 ? 32'h602 : 32'h0) | (p == 2 ? 32'h8 : 32'h0),
                32'd100000);
            apb(`OSL_ADDR_CTRL, 1'b1, 32'h1);
            apb(`OSL_ADDR_SPEED, 1'b0, 32'h0);
            check("start speed", 32'h1, 32'(rd >= 20000 && rd <= 21000));
            check("search dir", 32'h0, dir_ccw_out);
            wait_idle();
            check("found stat", 32'h12, rd & 32'h17);
            check("origin pos", p == 0 ? 18 : (p == 1 ? 12 : 5), pos);
            if (p != 1) begin
                check("prox gap", 32'h1, 32'(gap >= 398 && gap <= 402));
            end
        end
    endtask
    task automatic t_limit();
        int n;
        for (int c = 0; c < 2; c++) begin
            setup(32'h1b0 | (c << 2), 32'd100000);
            apb(`OSL_ADDR_CTRL, 1'b1, 32'h1);
            wait_idle();
            check("limit stat", c ? 32'h4 : 32'h6, rd & 32'h17);
            check("limit pos", -8, pos);
        end
        setup(32'hb0, 32'd100000);
        apb(`OSL_ADDR_CTRL, 1'b1, 32'h1);
        @(posedge pclk);
        check("ccw dir", 32'h1, dir_ccw_out);
        n = 0;
        while (dir_ccw_out !== 1'b0 && n < 40000) begin
            @(posedge pclk);
            n++;
        end
        give_up(n >= 40000);
        check("reverse pos", -8, pos);
        apb(`OSL_ADDR_CTRL, 1'b1, 32'h2);
        wait_idle();
        check("no error", 32'h0, rd & 32'h4);
    endtask
    task automatic t_jog();
        int n;
        setup(32'h0, 32'd100000);
        apb(`OSL_ADDR_CTRL, 1'b1, 32'h8);
        n = 0;
        while (pos > -10 && n < 40000) begin
            @(posedge pclk);
            n++;
        end
        check("jog past limit", 32'h1, 32'(pos <= -10));
        apb(`OSL_ADDR_CTRL, 1'b1, 32'h2);
        wait_idle();
        setup(32'h1, 32'd100000);
        apb(`OSL_ADDR_CTRL, 1'b1, 32'h8);
        wait_idle();
        check("jog limit stop", -8, pos);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_reset();
        t_refuse();
        t_pattern();
        t_limit();
        t_jog();
        report_and_stop();
    end
endmodule
